// [rtl/swc_pkg.sv]
/*
 * shared constants of the shutdown/wake-up controller: register
 * offsets, field positions, reset values, key and timing counts.
 * assumes: byte addresses on an 8-bit register address port.
 */
package swc_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_STATE = 8'h10;
  // command register fields
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam logic [7:0] SUPPLY_OFF_OUT_KEY = 8'hA5;
  localparam int CMD_SD_BIT = 0;
  // configuration register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CPT_LSB = 4;
  localparam int CFG_TEN_BIT = 16;
  localparam int CFG_CEN_BIT = 17;
  localparam logic [31:0] CFG_RESET = 32'h00000003;
  // status and mask layout
  localparam int ST_WAKE_BIT = 0;
  localparam int ST_TIM_BIT = 16;
  localparam int ST_CLK_BIT = 17;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // packed flag indices inside the block
  localparam int FLG_WAKE = 0;
  localparam int FLG_TIM = 1;
  localparam int FLG_CLK = 2;
  // state readout bits
  localparam int STATE_OFF_BIT = 0;
  localparam int STATE_PEND_BIT = 1;
  // timing, in slow clock cycles
  localparam int SD_DELAY_CYC = 2;
  localparam int DEB_UNIT = 16;
  // wake input edge selection
  typedef enum logic [1:0] {
    SWC_EDGE_NONE = 2'b00,
    SWC_EDGE_RISE = 2'b01,
    SWC_EDGE_FALL = 2'b10,
    SWC_EDGE_BOTH = 2'b11
  } swc_edge_t;
endpackage

// [rtl/swc_sync.sv]
/*
 * two-flop synchroniser with rising edge detection, one lane per bit.
 * assumes: raw inputs may be asynchronous to ref_clk; levels are held
 * for at least two clock periods.
 */
`timescale 1ns/1ns
module swc_sync
  import swc_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] prev;
  } swc_sync_t;
  swc_sync_t s;
  swc_sync_t next_s;

  // stage one feeds only stage two, to settle metastability
  always_comb begin
    next_s = s;
    next_s.s1 = raw;
    next_s.s2 = s.s1;
    next_s.prev = s.s2;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.s2 & ~s.prev;

  property p_alarm_rise;
    @(posedge ref_clk) disable iff (rst)
    $rose(raw[0]) |-> ##2 rise[0];
  endproperty
  a_alarm_rise: assert property (p_alarm_rise)
    else $error("alarm edge not seen two cycles after input rose");
endmodule

// [rtl/swc_debounce.sv]
/*
 * wake input transition detector with debounce counter.
 * assumes: wake_in is synchronous to ref_clk; configuration inputs
 * come from registers of the same clock.
 */
`timescale 1ns/1ns
module swc_debounce
  import swc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wake_in,
  input wire logic [1:0] edge_sel,
  input wire logic [3:0] deb_cnt,
  output logic wake_event
);
  typedef struct packed {
    logic lvl;
    logic armed;
    logic [CNT_W-1:0] cnt;
  } swc_deb_t;
  swc_deb_t s;
  swc_deb_t next_s;
  logic chg;
  logic qualify;
  logic [CNT_W-1:0] target;

  assign target = CNT_W'(deb_cnt) * CNT_W'(DEB_UNIT);
  assign chg = wake_in != s.lvl;

  always_comb begin
    case (swc_edge_t'(edge_sel))
      SWC_EDGE_RISE: qualify = wake_in;
      SWC_EDGE_FALL: qualify = !wake_in;
      SWC_EDGE_BOTH: qualify = 1'b1;
      default: qualify = 1'b0;
    endcase
  end

  assign wake_event = s.armed && !chg && s.cnt == target && qualify_on();

  function automatic logic qualify_on();
    return edge_sel != SWC_EDGE_NONE;
  endfunction

  always_comb begin
    next_s = s;
    next_s.lvl = wake_in;
    if (chg) begin
      next_s.armed = qualify;
      next_s.cnt = '0;
    end else if (s.armed) begin
      if (s.cnt == target) begin
        next_s.armed = 1'b0;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  property p_deb_change;
    @(posedge ref_clk) disable iff (rst)
    chg |=> (s.cnt == '0);
  endproperty
  a_deb_change: assert property (p_deb_change)
    else $error("counter not cleared after input change");

  property p_deb_exact;
    @(posedge ref_clk) disable iff (rst)
    wake_event |-> (s.cnt == target) && (wake_in == s.lvl);
  endproperty
  a_deb_exact: assert property (p_deb_exact)
    else $error("wake event before debounce count reached");

  property p_deb_off;
    @(posedge ref_clk) disable iff (rst)
    (edge_sel == SWC_EDGE_NONE) |-> !wake_event;
  endproperty
  a_deb_off: assert property (p_deb_off)
    else $error("wake event while detection disabled");
endmodule

// [rtl/swc_power_down_unit.sv]
/*
 * power down unit: key-protected shutdown command driving the supply
 * off output, wake-up by debounced input or enabled alarms, read-clear
 * wake status, interrupt mask and a level interrupt.
 * assumes: ref_clk is the free-running slow clock; register port and
 * wake input are synchronous to it; alarms may be asynchronous.
 */
`timescale 1ns/1ns
module swc_power_down_unit
  import swc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic wake_input0,
  input wire logic timer_alarm,
  input wire logic clock_alarm,
  output logic supply_off_out,
  output logic irq
);
  localparam int SD_PW = SD_DELAY_CYC - 1;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic [3:0] deb_cnt;
    logic tim_en;
    logic clk_en;
    logic [2:0] flags;
    logic [2:0] mask;
    logic [SD_PW-1:0] sd_pipe;
    logic supply_off;
    logic irq;
    logic [31:0] rdata;
  } swc_state_t;

  // reset image: configuration as documented, everything else clear
  localparam swc_state_t RST_S = '{
    edge_sel: CFG_RESET[CFG_MODE_LSB +: 2],
    deb_cnt: CFG_RESET[CFG_CPT_LSB +: 4],
    tim_en: CFG_RESET[CFG_TEN_BIT],
    clk_en: CFG_RESET[CFG_CEN_BIT],
    flags: FLAGS_RESET,
    mask: MASK_RESET,
    default: '0
  };

  swc_state_t s;
  swc_state_t next_s;
  logic [1:0] alarm_rise;
  logic wake_event;
  logic cmd_hit;
  logic cmd_ok;
  logic cmd_fire;
  logic tim_ev;
  logic clk_ev;
  logic release_ev;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // places the three event bits at their register positions
  function automatic logic [31:0] flags_to_word(input logic [2:0] f);
    logic [31:0] w;
    w = 32'h00000000;
    w[ST_WAKE_BIT] = f[FLG_WAKE];
    w[ST_TIM_BIT] = f[FLG_TIM];
    w[ST_CLK_BIT] = f[FLG_CLK];
    return w;
  endfunction

  // gathers the three event bits out of a register word
  function automatic logic [2:0] word_to_flags(input logic [31:0] w);
    logic [2:0] f;
    f = 3'h0;
    f[FLG_WAKE] = w[ST_WAKE_BIT];
    f[FLG_TIM] = w[ST_TIM_BIT];
    f[FLG_CLK] = w[ST_CLK_BIT];
    return f;
  endfunction

  // wake input transition detection and debounce
  swc_debounce #(
    .CNT_W(CNT_W)
  ) u_debounce (
    .ref_clk(ref_clk),
    .rst(rst),
    .wake_in(wake_input0),
    .edge_sel(s.edge_sel),
    .deb_cnt(s.deb_cnt),
    .wake_event(wake_event)
  );

  swc_sync #(
    .W(2)
  ) u_alarm_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw({clock_alarm, timer_alarm}),
    .rise(alarm_rise)
  );

  assign cmd_hit = reg_wr && reg_addr == OFF_CMD;
  assign cmd_ok = cmd_hit && reg_wdata[KEY_MSB:KEY_LSB] == SUPPLY_OFF_OUT_KEY &&
                  reg_wdata[CMD_SD_BIT];
  assign cmd_fire = s.sd_pipe[SD_PW-1];

  assign tim_ev = alarm_rise[0] && s.tim_en;
  assign clk_ev = alarm_rise[1] && s.clk_en;
  assign release_ev = wake_event || tim_ev || clk_ev;
  assign flag_set = {clk_ev, tim_ev, wake_event};

  // read clears
  // status clears: whole register on read, chosen bits on write-one
  always_comb begin
    flag_clr = 3'h0;
    if (reg_rd && reg_addr == OFF_STAT) begin
      flag_clr = 3'h7;
    end
    if (reg_wr && reg_addr == OFF_STAT) begin
      flag_clr = flag_clr | word_to_flags(reg_wdata);
    end
  end

  // next state of the whole unit
  always_comb begin
    next_s = s;
    // a rejected write never enters the pipe, so nothing is half done
    next_s.sd_pipe = SD_PW'({s.sd_pipe, cmd_ok});
    if (release_ev) begin
      next_s.supply_off = 1'b0;
    end else if (cmd_fire) begin
      next_s.supply_off = 1'b1;
    end
    // configuration write
    if (reg_wr && reg_addr == OFF_CFG) begin
      next_s.edge_sel = reg_wdata[CFG_MODE_LSB +: 2];
      next_s.deb_cnt = reg_wdata[CFG_CPT_LSB +: 4];
      next_s.tim_en = reg_wdata[CFG_TEN_BIT];
      next_s.clk_en = reg_wdata[CFG_CEN_BIT];
    end
    if (reg_wr && reg_addr == OFF_MASK) begin
      next_s.mask = word_to_flags(reg_wdata);
    end
    next_s.flags = (s.flags & ~flag_clr) | flag_set;
    next_s.irq = |(next_s.flags & next_s.mask);
    // read data stand for one cycle only, zero otherwise
    next_s.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        OFF_CFG: begin
          next_s.rdata[CFG_MODE_LSB +: 2] = s.edge_sel;
          next_s.rdata[CFG_CPT_LSB +: 4] = s.deb_cnt;
          next_s.rdata[CFG_TEN_BIT] = s.tim_en;
          next_s.rdata[CFG_CEN_BIT] = s.clk_en;
        end
        OFF_STAT: next_s.rdata = flags_to_word(s.flags);
        OFF_MASK: next_s.rdata = flags_to_word(s.mask);
        OFF_STATE: begin
          next_s.rdata[STATE_OFF_BIT] = s.supply_off;
          next_s.rdata[STATE_PEND_BIT] = |s.sd_pipe;
        end
        default: next_s.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign supply_off_out = s.supply_off;
  assign irq = s.irq;

  property p_cmd_takes;
    @(posedge ref_clk) disable iff (rst)
    cmd_ok |-> ##2 (supply_off_out || $past(release_ev));
  endproperty
  a_cmd_takes: assert property (p_cmd_takes)
    else $error("accepted shutdown did not assert output");

  property p_cmd_not_early;
    @(posedge ref_clk) disable iff (rst)
    cmd_ok && !supply_off_out && !cmd_fire |=> !supply_off_out;
  endproperty
  a_cmd_not_early: assert property (p_cmd_not_early)
    else $error("shutdown asserted one cycle after write");

  property p_bad_key;
    @(posedge ref_clk) disable iff (rst)
    cmd_hit && reg_wdata[KEY_MSB:KEY_LSB] != SUPPLY_OFF_OUT_KEY
      |-> ##2 !$rose(supply_off_out);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("write with wrong key asserted output");

  property p_zero_bit;
    @(posedge ref_clk) disable iff (rst)
    cmd_hit && !reg_wdata[CMD_SD_BIT] |-> ##2 !$rose(supply_off_out);
  endproperty
  a_zero_bit: assert property (p_zero_bit)
    else $error("write of zero shutdown bit asserted output");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
    supply_off_out && !release_ev |=> supply_off_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("output dropped without wake source");

  property p_release;
    @(posedge ref_clk) disable iff (rst)
    release_ev |=> !supply_off_out;
  endproperty
  a_release: assert property (p_release)
    else $error("wake source did not release output");

  property p_timer_off;
    @(posedge ref_clk) disable iff (rst)
    alarm_rise[0] && !s.tim_en && supply_off_out && !wake_event && !clk_ev
      |=> supply_off_out && !$rose(s.flags[FLG_TIM]);
  endproperty
  a_timer_off: assert property (p_timer_off)
    else $error("disabled timer alarm had an effect");

  property p_clock_off;
    @(posedge ref_clk) disable iff (rst)
    alarm_rise[1] && !s.clk_en |=> !$rose(s.flags[FLG_CLK]);
  endproperty
  a_clock_off: assert property (p_clock_off)
    else $error("disabled clock alarm set its flag");

  property p_read_clear;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STAT && flag_set == 3'h0 |=> s.flags == 3'h0;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear flags");

  property p_set_wins;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STAT && wake_event |=> s.flags[FLG_WAKE];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in status read cycle");

  property p_tim_report;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STAT
      |=> reg_rdata[ST_TIM_BIT] == $past(s.flags[FLG_TIM]);
  endproperty
  a_tim_report: assert property (p_tim_report)
    else $error("timer flag misreported");

  property p_clk_report;
    @(posedge ref_clk) disable iff (rst)
    reg_rd && reg_addr == OFF_STAT
      |=> reg_rdata[ST_CLK_BIT] == $past(s.flags[FLG_CLK]);
  endproperty
  a_clk_report: assert property (p_clk_report)
    else $error("clock flag misreported");
endmodule

// [testbench/swc_partner.sv]
/*
 * far side model: the wake-up button and the alarm sources of the
 * real-time timer and real-time clock.
 * assumes: the bench calls its tasks; changes land just after ref_clk edges.
 */
`timescale 1ns/1ns
module swc_partner (
  input wire logic ref_clk,
  output logic wake_input0,
  output logic timer_alarm,
  output logic clock_alarm
);
  // idle levels from time zero
  initial begin
    wake_input0 = 1'b0;
    timer_alarm = 1'b0;
    clock_alarm = 1'b0;
  end
  // button level change, held until the next call
  task automatic set_wake(input logic lvl);
    @(posedge ref_clk);
    wake_input0 <= lvl;
  endtask
  // alarm raised then cleared
  // the source drops its flag again, else the next alarm has no edge
  task automatic alarm(input logic sel);
    @(posedge ref_clk);
    if (sel)
      clock_alarm <= 1'b1;
    else
      timer_alarm <= 1'b1;
    repeat (4) @(posedge ref_clk);
    clock_alarm <= 1'b0;
    timer_alarm <= 1'b0;
  endtask
endmodule

// [testbench/swc_power_down_unit_tb.sv]
/*
 * self-checking bench of the power down unit with the far side model.
 * assumes: read data stand one cycle after the read strobe; the supply
 * off output is registered.
 */
`timescale 1ns/1ns
module swc_power_down_unit_tb
  import swc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic wake_input0;
  logic timer_alarm;
  logic clock_alarm;
  logic supply_off_out;
  logic irq;
  int err_total = 0;
  int n_tests = 0;

  // 50 ns period slow clock
  always #25 ref_clk = ~ref_clk;

  swc_power_down_unit #(.CNT_W(8)) DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .wake_input0(wake_input0),
    .timer_alarm(timer_alarm),
    .clock_alarm(clock_alarm),
    .supply_off_out(supply_off_out),
    .irq(irq)
  );

  swc_partner u_far (
    .ref_clk(ref_clk),
    .wake_input0(wake_input0),
    .timer_alarm(timer_alarm),
    .clock_alarm(clock_alarm)
  );

  // case equality so an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // keyed command; output is up one edge after the write edge
  task automatic shut();
    wr(OFF_CMD, {SUPPLY_OFF_OUT_KEY, 24'h000001});
    @(posedge ref_clk);
  endtask

  task automatic t_reset();
    rd_chk(OFF_CFG, CFG_RESET);
    rd_chk(OFF_STAT, 32'h00000000);
    rd_chk(OFF_CMD, 32'h00000000);
    rd_chk(8'h14, 32'h00000000);
    check(supply_off_out, 32'h0);
  endtask

  // wrong key and a zero command bit both leave the output low
  task automatic t_key();
    wr(OFF_CMD, 32'h5A000001);
    wr(OFF_CMD, 32'hA5000000);
    repeat (3) @(posedge ref_clk);
    #1 check(supply_off_out, 32'h0);
    wr(OFF_CMD, 32'hA5000001);
    #1 check(supply_off_out, 32'h0);
    @(posedge ref_clk);
    #1 check(supply_off_out, 32'h1);
  endtask

  // rise detect, one debounce unit: the pin changes after edge P, the
  // unit takes it at P+1 and releases 16+1 edges later, at P+18
  task automatic t_deb();
    wr(OFF_CFG, 32'h00000011);
    u_far.set_wake(1'b1);
    repeat (17) @(posedge ref_clk);
    #1 check(supply_off_out, 32'h1);
    @(posedge ref_clk);
    #1 check(supply_off_out, 32'h0);
    rd_chk(OFF_STAT, 32'h00000001);
    rd_chk(OFF_STAT, 32'h00000000);
    u_far.set_wake(1'b0);
    shut();
    // short pulse: the fall stops the count, nothing is released
    u_far.set_wake(1'b1);
    repeat (8) @(posedge ref_clk);
    u_far.set_wake(1'b0);
    repeat (40) @(posedge ref_clk);
    #1 check(supply_off_out, 32'h1);
    rd_chk(OFF_STAT, 32'h00000000);
    // counting restarts from zero on the next rise
    u_far.set_wake(1'b1);
    repeat (17) @(posedge ref_clk);
    #1 check(supply_off_out, 32'h1);
    @(posedge ref_clk);
    #1 check(supply_off_out, 32'h0);
  endtask

  // every edge selection with no debounce; wake starts high, and a
  // selected change releases two edges after the pin moves
  task automatic t_modes();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(OFF_CFG, {30'h0, m});
      shut();
      u_far.set_wake(1'b0);
      repeat (2) @(posedge ref_clk);
      #1 check(supply_off_out, {31'h0, ~m[1]});
      shut();
      u_far.set_wake(1'b1);
      repeat (2) @(posedge ref_clk);
      #1 check(supply_off_out, {31'h0, ~m[0]});
    end
    rd_chk(OFF_STAT, 32'h00000001);
  endtask

  // each alarm disabled first, then enabled
  task automatic t_alarm();
    for (int s = 0; s < 2; s++) begin
      wr(OFF_CFG, 32'h00000000);
      shut();
      u_far.alarm(s[0]);
      #1 check(supply_off_out, 32'h1);
      rd_chk(OFF_STAT, 32'h00000000);
      wr(OFF_CFG, 32'h00010000 << s);
      u_far.alarm(s[0]);
      #1 check(supply_off_out, 32'h0);
      rd_chk(OFF_STAT, 32'h00010000 << s);
    end
  endtask

  // interrupt raised, masked, unmasked, cleared by write-one
  task automatic t_irq();
    wr(OFF_CFG, 32'h00010000);
    wr(OFF_MASK, 32'h00010000);
    u_far.alarm(1'b0);
    #1 check(irq, 32'h1);
    wr(OFF_MASK, 32'h00000000);
    @(posedge ref_clk);
    #1 check(irq, 32'h0);
    wr(OFF_MASK, 32'h00010000);
    @(posedge ref_clk);
    #1 check(irq, 32'h1);
    rd_chk(OFF_MASK, 32'h00010000);
    wr(OFF_STAT, 32'h00010000);
    @(posedge ref_clk);
    #1 check(irq, 32'h0);
    rd_chk(OFF_STAT, 32'h00000000);
  endtask

  // a wake event lands in the very cycle of a status read: the read
  // returns the old flags and the event survives for the next read
  task automatic t_race();
    wr(OFF_CFG, CFG_RESET);
    u_far.set_wake(1'b0);
    rd_chk(OFF_STAT, 32'h00000000);
    rd_chk(OFF_STAT, 32'h00000001);
  endtask

  // mid-run reset while the supply is off brings every register back
  task automatic t_rerst();
    shut();
    rd_chk(OFF_STATE, 32'h00000001);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1 check(supply_off_out, 32'h0);
    rd_chk(OFF_CFG, CFG_RESET);
    rd_chk(OFF_MASK, 32'h00000000);
    rd_chk(OFF_STAT, 32'h00000000);
    check(irq, 32'h0);
  endtask

  task automatic end_of_test();
    $display("mismatches=%0d comparisons=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // idle bus and reset from time zero; main sequence after three cycles
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_key();
    t_deb();
    t_modes();
    t_alarm();
    t_irq();
    t_race();
    t_rerst();
    end_of_test();
  end

  // watchdog, well beyond the expected length of the run
  initial begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
endmodule
